// *** rrp_defines.svh ***
`ifndef RRP_DEFINES_SVH
`define RRP_DEFINES_SVH
// command framing bytes
`define RRP_HDR_BYTE 8'hff
`define RRP_ESC_BYTE 8'hfe
`define RRP_ACK_BYTE 8'h06
`define RRP_NAK_BYTE 8'h15
`define RRP_ESC_OFFS 8'h80
`define RRP_READ_SIZE 8'h02
// timing
`define RRP_CLK_MHZ 100
`define RRP_CMD_MARGIN_US 20
`define RRP_CMD_MARGIN_CYC ((`RRP_CMD_MARGIN_US) * (`RRP_CLK_MHZ))
`define RRP_NV_STALL_MS 21
`define RRP_NV_STALL_CYC ((`RRP_NV_STALL_MS) * 1000 * (`RRP_CLK_MHZ))
`endif

// *** rrp_host.sv ***
`timescale 1ns/1ps
// host side: frames read requests byte by byte
module rrp_host (
  input wire logic mclk,
  output rrp_pkg::rrp_byte_s rx,
  output logic cmd_n
);
  import rrp_pkg::*;
  initial begin
    rx = '0;
    cmd_n = 1'b1;
  end
  // released data shows the inverse so a stale byte cannot pass
  task automatic send(input logic [7:0] b);
    @(negedge mclk) rx <= {1'b1, b};
    @(negedge mclk) rx <= {1'b0, ~b};
  endtask : send
  // unless ab is set, select stays low well past the command, which is harmless
  task automatic frame(input logic [7:0] r, input logic [7:0] sz, input logic ab);
    cmd_n <= 1'b0;
    send(8'hff);
    send(sz);
    send(8'hfe);
    if (ab) cmd_n <= 1'b1;
    send(r);
  endtask : frame
endmodule : rrp_host

// *** rrp_parser.sv ***
`timescale 1ns/1ps
`include "rrp_defines.svh"
// How it works
// - a read is header 0xff, size, escape, register number, taken in that order.
// - a valid read is answered with ack 0x06, the register number, then its value.
// - the value byte goes out raw, with no escape, even at 128 or more.
// - an unknown register number gets the single nak byte 0x15.
// - a non-volatile write seen while idle stalls the parser for 21 ms of enabled cycles, ignoring input; one during a frame or answer is dropped.
// - bytes reach the parser only while cmd_n is low; raising it aborts a frame.
// - escape 0xfe marks a read; the byte after it is the register number, taken as sent.
module rrp_parser #(
  parameter int unsigned STALL_CYC = `RRP_NV_STALL_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic cmd_n,
  input rrp_pkg::rrp_byte_s rx,
  input rrp_pkg::rrp_lookup_s lookup,
  input wire logic nv_write,
  input wire logic tx_ready,
  output logic [7:0] lookup_addr_q,
  output rrp_pkg::rrp_byte_s tx_q,
  output logic busy_q,
  output logic stall_q
);
  import rrp_pkg::*;

  // ************************************
  // frame parser
  // ************************************
  rrp_state_e state_q;
  logic [7:0] left_q;
  logic esc_q;
  logic start_q;
  logic nak_q;
  logic [7:0] val_q;
  logic [31:0] stall_cnt_q;
  logic seq_busy;

  // main sequencing; cmd_n high drops any partial frame
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RRP_IDLE;
      left_q <= 8'h00;
      esc_q <= 1'b0;
      lookup_addr_q <= 8'h00;
      start_q <= 1'b0;
      nak_q <= 1'b0;
      val_q <= 8'h00;
      stall_cnt_q <= 32'h0;
    end else if (clk_en) begin
      start_q <= 1'b0;
      case (state_q)
        RRP_IDLE: begin
          esc_q <= 1'b0;
          if (nv_write) begin
            state_q <= RRP_STALL;
            stall_cnt_q <= STALL_CYC;
          end else if (!cmd_n && rx.vld && rx.data == `RRP_HDR_BYTE) begin
            state_q <= RRP_SIZE;
          end
        end
        RRP_SIZE: begin
          if (cmd_n) begin
            state_q <= RRP_IDLE;
          end else if (rx.vld) begin
            // only a two-byte body is a read here
            if (rx.data == `RRP_READ_SIZE) begin
              left_q <= rx.data;
              state_q <= RRP_BODY;
            end else begin
              state_q <= RRP_IDLE;
            end
          end
        end
        RRP_BODY: begin
          if (cmd_n) begin
            state_q <= RRP_IDLE;
          end else if (rx.vld) begin
            left_q <= left_q - 8'h01;
            if (left_q == `RRP_READ_SIZE) begin
              // first body byte must be the escape marking a read
              if (rx.data == `RRP_ESC_BYTE) begin
                esc_q <= 1'b1;
              end else begin
                state_q <= RRP_IDLE;
              end
            end else if (esc_q) begin
              // escape seen: this byte is the register to read, taken as sent
              lookup_addr_q <= rx.data;
              state_q <= RRP_LOOK;
            end else begin
              state_q <= RRP_IDLE;
            end
          end
        end
        RRP_LOOK: begin
          // lookup answers combinationally from lookup_addr_q
          nak_q <= !lookup.hit;
          val_q <= lookup.value;
          if (!seq_busy) begin
            start_q <= 1'b1;
            state_q <= RRP_SEND;
          end
        end
        RRP_SEND: begin
          if (!start_q && !seq_busy) begin
            state_q <= RRP_IDLE;
          end
        end
        RRP_STALL: begin
          // input bytes fall on the floor while flash is busy
          if (stall_cnt_q <= 32'h1) begin
            state_q <= RRP_IDLE;
          end
          stall_cnt_q <= stall_cnt_q - 32'h1;
        end
        default: state_q <= RRP_IDLE;
      endcase
    end
  end

  // status flags, registered
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      stall_q <= 1'b0;
    end else if (clk_en) begin
      busy_q <= (state_q != RRP_IDLE);
      stall_q <= (state_q == RRP_STALL);
    end
  end

  // ************************************
  // response output
  // ************************************
  rrp_tx_seq u_tx (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .start(start_q),
    .nak(nak_q),
    .reg_num(lookup_addr_q),
    .reg_val(val_q),
    .tx_ready(tx_ready),
    .tx_q(tx_q),
    .busy_q(seq_busy)
  );
endmodule : rrp_parser

// *** rrp_parser_asserts.sv ***
`timescale 1ns/1ps
`include "rrp_defines.svh"
// ****************
// parser checker
// ****************
module rrp_parser_chk #(
  parameter int unsigned STALL_CYC = 50
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic cmd_n,
  input rrp_pkg::rrp_byte_s rx,
  input rrp_pkg::rrp_lookup_s lookup,
  input wire logic nv_write,
  input wire logic tx_ready,
  input wire logic [7:0] lookup_addr_q,
  input rrp_pkg::rrp_byte_s tx_q,
  input wire logic busy_q,
  input wire logic stall_q
);
  import rrp_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // output bytes are single pulses, gated by the transmitter
  property p_vld_pulse; tx_q.vld |=> !tx_q.vld; endproperty
  a_vld_pulse: assert property (p_vld_pulse) else $error("tx strobe too long");
  property p_ready; tx_q.vld |-> $past(tx_ready); endproperty
  a_ready: assert property (p_ready) else $error("tx byte without ready");
  property p_ack_hit; tx_q.vld && tx_q.data == `RRP_ACK_BYTE |-> lookup.hit; endproperty
  a_ack_hit: assert property (p_ack_hit) else $error("ack for unknown register");
  // a nak is the only byte of its answer
  property p_nak;
    tx_q.vld && tx_q.data == `RRP_NAK_BYTE && !lookup.hit |=> !tx_q.vld [*4];
  endproperty
  a_nak: assert property (p_nak) else $error("bytes after nak");
  // flash stall: long, silent, deaf
  property p_stall_len; $rose(stall_q) |-> stall_q [*8]; endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall too short");
  property p_stall_quiet; stall_q |-> !tx_q.vld; endproperty
  a_stall_quiet: assert property (p_stall_quiet) else $error("tx during stall");
  property p_stall_hold; stall_q |=> $stable(lookup_addr_q); endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("input taken in stall");
  property p_cmd; $changed(lookup_addr_q) |-> !$past(cmd_n); endproperty
  a_cmd: assert property (p_cmd) else $error("byte taken with select high");
  // enabled cycles spent in the stall; frozen cycles do not count
  logic [31:0] stall_len_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stall_len_q <= 32'h0;
    end else if (clk_en) begin
      stall_len_q <= stall_q ? (stall_len_q + 32'h1) : 32'h0;
    end
  end
  // the stall is bounded: exactly the configured count, never longer
  property p_stall_cyc; $fell(stall_q) |-> stall_len_q == STALL_CYC; endproperty
  a_stall_cyc: assert property (p_stall_cyc) else $error("stall length off");
  // a low enable freezes tx_q, stall_q and busy_q
  property p_freeze;
    !clk_en |=> $stable(tx_q) && $stable(stall_q) && $stable(busy_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  c_ack: cover property (tx_q.vld && tx_q.data == `RRP_ACK_BYTE);
  c_nak: cover property (tx_q.vld && tx_q.data == `RRP_NAK_BYTE && !lookup.hit);
  c_stall: cover property ($rose(stall_q));
endmodule : rrp_parser_chk
bind rrp_parser rrp_parser_chk #(.STALL_CYC(STALL_CYC)) i_chk (.mclk(mclk), .rst_n(rst_n),
  .clk_en(clk_en), .cmd_n(cmd_n), .rx(rx), .lookup(lookup), .nv_write(nv_write),
  .tx_ready(tx_ready), .lookup_addr_q(lookup_addr_q), .tx_q(tx_q), .busy_q(busy_q),
  .stall_q(stall_q));

// *** rrp_pkg.sv ***
package rrp_pkg;
  // byte with a strobe
  typedef struct packed {
    logic vld;
    logic [7:0] data;
  } rrp_byte_s;

  // register file lookup answer: hit flag and value
  typedef struct packed {
    logic hit;
    logic [7:0] value;
  } rrp_lookup_s;

  typedef enum logic [2:0] {
    RRP_IDLE,
    RRP_SIZE,
    RRP_BODY,
    RRP_LOOK,
    RRP_SEND,
    RRP_STALL
  } rrp_state_e;
endpackage : rrp_pkg

// *** rrp_tx_seq.sv ***
`timescale 1ns/1ps
`include "rrp_defines.svh"
// ************************************
// response byte sequencer
// ************************************
module rrp_tx_seq (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic nak,
  input wire logic [7:0] reg_num,
  input wire logic [7:0] reg_val,
  input wire logic tx_ready,
  output rrp_pkg::rrp_byte_s tx_q,
  output logic busy_q
);
  import rrp_pkg::*;

  logic [1:0] idx_q;
  logic [1:0] last_q;
  logic [7:0] num_q;
  logic [7:0] val_q;

  // byte picked by position; value sent raw, never escaped
  function automatic logic [7:0] pick(input logic [1:0] i, input logic [7:0] n,
                                      input logic [7:0] v, input logic k);
    if (k) begin
      pick = `RRP_NAK_BYTE;
    end else begin
      case (i)
        2'h0: pick = `RRP_ACK_BYTE;
        2'h1: pick = n;
        default: pick = v;
      endcase
    end
  endfunction : pick

  logic nak_q;

  // one byte handed out per accepted tx_ready slot
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= 2'h0;
      last_q <= 2'h0;
      num_q <= 8'h00;
      val_q <= 8'h00;
      nak_q <= 1'b0;
      busy_q <= 1'b0;
      tx_q <= '0;
    end else if (clk_en) begin
      tx_q.vld <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        idx_q <= 2'h0;
        last_q <= nak ? 2'h0 : 2'h2;
        num_q <= reg_num;
        val_q <= reg_val;
        nak_q <= nak;
      end else if (busy_q && tx_ready && !tx_q.vld) begin
        tx_q.vld <= 1'b1;
        tx_q.data <= pick(idx_q, num_q, val_q, nak_q);
        if (idx_q == last_q) begin
          busy_q <= 1'b0;
        end else begin
          idx_q <= idx_q + 2'h1;
        end
      end
    end
  end
endmodule : rrp_tx_seq

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import rrp_pkg::*;
  logic mclk = 0, rst_n = 0, nv_write = 0, tx_ready = 1, clk_en = 1, cmd_n;
  logic [7:0] lookup_addr_q;
  rrp_byte_s rx, tx_q;
  rrp_lookup_s lookup;
  logic busy_q, stall_q;
  int failures = 0, tests_run = 0, seed = 89, cyc = 0;
  logic [7:0] got[$], exp[$];
  // register file stand-in: low quarter exists, values reach 128 and up
  function automatic logic [7:0] val(input logic [7:0] a);
    return (a * 8'h25) ^ 8'h9c;
  endfunction : val
  assign lookup = {lookup_addr_q[7:6] == 2'h0, val(lookup_addr_q)};
  rrp_parser #(.STALL_CYC(50)) i_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .cmd_n(cmd_n), .rx(rx), .lookup(lookup), .nv_write(nv_write), .tx_ready(tx_ready),
    .lookup_addr_q(lookup_addr_q), .tx_q(tx_q), .busy_q(busy_q), .stall_q(stall_q));
  rrp_host i_host (.mclk(mclk), .rx(rx), .cmd_n(cmd_n));
  initial forever #5 mclk = ~mclk;
  // capture answers, jitter the transmitter, and cut a hang short
  always @(negedge mclk) if (tx_q.vld === 1'b1) got.push_back(tx_q.data);
  always @(negedge mclk) tx_ready <= ($random(seed) % 4) != 0;
  always @(posedge mclk) if (++cyc == 20000) begin failures++; final_report(); end
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check
  task automatic final_report;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // one request; aborted, stalled or wrong-size ones expect silence, an unknown register expects one nak
  task automatic run(input logic [7:0] r, input logic [7:0] sz, input logic ab, st);
    got = {};
    exp = {};
    if (!ab && !st && sz == 8'h02) begin
      exp.push_back((r[7:6] == 2'h0) ? 8'h06 : 8'h15);
      if (r[7:6] == 2'h0) begin
        exp.push_back(r);
        exp.push_back(val(r));
      end
    end
    // stall start, then a short freeze inside it
    if (st) begin
      @(negedge mclk) nv_write <= 1'b1;
      @(negedge mclk) nv_write <= 1'b0;
      clk_en <= 1'b0;
      repeat (5) @(negedge mclk);
      clk_en <= 1'b1;
    end
    i_host.frame(r, sz, ab);
    if (st) check({7'h00, stall_q}, 8'h01);
    repeat (4) @(negedge mclk);
    for (int i = 0; i < 100 && busy_q !== 1'b0; i++) @(negedge mclk);
    repeat (3) @(negedge mclk);
    check({7'h00, busy_q}, 8'h00);
    if (exp.size() > 0) check(lookup_addr_q, r);
    check(8'(got.size()), 8'(exp.size()));
    foreach (exp[i]) if (i < got.size()) check(got[i], exp[i]);
    $display("test done reg=%h size=%h abort=%b stall=%b", r, sz, ab, st);
  endtask : run
  initial begin
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    for (int k = 0; k < 16; k++) run(8'($random(seed)) & 8'h7f, 8'h02, 0, 0);
    run(8'h3f, 8'h02, 0, 0);
    run(8'h40, 8'h02, 0, 0);
    run(8'h05, 8'h03, 0, 0);
    run(8'h05, 8'h02, 1, 0);
    run(8'h07, 8'h02, 0, 1);
    run(8'h07, 8'h02, 0, 0);
    final_report();
  end
endmodule : tb
